// ### pkg/periodic_timer_pkg.sv
// Shared constants for the periodic timer
package periodic_timer_pkg;
  // Register byte addresses
  localparam logic [7:0] OFS_CONTROL_0 = 8'h00;
  localparam logic [7:0] OFS_CONTROL_1 = 8'h04;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h08;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_CMP_A_LOW = 8'h10;
  localparam logic [7:0] OFS_CMP_A_HIGH = 8'h14;
  localparam logic [7:0] OFS_PERIOD_LOW = 8'h18;
  localparam logic [7:0] OFS_PERIOD_HIGH = 8'h1C;
  localparam logic [7:0] OFS_FLAGS = 8'h20;
  // Control 0 fields
  localparam int PAUSE_BIT = 7;
  localparam int CLK_SEL_LSB = 4;
  localparam int TIMER_ON_BIT = 3;
  localparam logic [7:0] CONTROL_0_MASK = 8'hF8;
  // Control 1 fields
  localparam int MODE_LSB = 6;
  localparam int PIN_FN_LSB = 4;
  localparam int INIT_LEVEL_BIT = 3;
  localparam int POLARITY_BIT = 2;
  localparam int CAP_SRC_BIT = 1;
  localparam int CLEAR_SEL_BIT = 0;
  // Flags register fields
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [9:0] VALUE_RESET = 10'h000;
  // Counter clock select codes
  localparam logic [2:0] CKS_SYS4 = 3'h0;
  localparam logic [2:0] CKS_SYS = 3'h1;
  localparam logic [2:0] CKS_H16 = 3'h2;
  localparam logic [2:0] CKS_H64 = 3'h3;
  localparam logic [2:0] CKS_SUB0 = 3'h4;
  localparam logic [2:0] CKS_SUB1 = 3'h5;
  localparam logic [2:0] CKS_EXT_RISE = 3'h6;
  // Pin function codes, meaning depends on mode
  localparam logic [1:0] PF_0 = 2'h0;
  localparam logic [1:0] PF_1 = 2'h1;
  localparam logic [1:0] PF_2 = 2'h2;
  localparam logic [1:0] PF_3 = 2'h3;
  // Prescaler masks, sub clock divider
  localparam logic [5:0] SYS4_MASK = 6'h03;
  localparam logic [5:0] H16_MASK = 6'h0F;
  localparam logic [5:0] H64_MASK = 6'h3F;
  localparam logic [7:0] SUB_DIV_LAST = 8'hF9;
  typedef enum logic [1:0] {MODE_COMPARE, MODE_CAPTURE, MODE_PWM, MODE_TIMER} mode_e;
endpackage

// ### verification/periodic_timer_tb_top.sv
// Self-checking bench for the periodic timer
`timescale 1ns/100ps
module periodic_timer_tb_top
  import periodic_timer_pkg::*;
;
  logic clk;
  logic nrst;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic ack;
  logic ext_pin;
  logic cap_pin;
  logic pin;
  logic pinb;
  logic fa;
  logic fp;
  int errors;
  int comparisons;

  periodic_timer i_periodic_timer (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .external_clock_pin(ext_pin), .capture_input_pin(cap_pin),
    .timer_output_pin(pin), .timer_output_inverted_pin(pinb),
    .compare_a_match_flag(fa), .period_match_flag(fp));
  timer_pin_partner i_timer_pin_partner (.clk(clk), .external_clock_pin(ext_pin),
    .capture_input_pin(cap_pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  // Request held until ack is seen high at a rising edge; upper data bytes
  // carry junk so an ignored lane would show
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_i <= {a, ~d, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    wb(1'b0, a, 8'h00, 4'hF, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    chk({8'h00, q}, {8'h00, e});
  endtask

  task automatic setv(input logic [7:0] a, input logic [9:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, {6'h00, v[9:8]});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // High byte first, so the low byte comes from the same sample
  task automatic cnt_chk(input logic [9:0] v);
    logic [7:0] h;
    logic [7:0] l;
    repeat (4) @(posedge clk);
    rd(OFS_COUNT_HIGH, h);
    rd(OFS_COUNT_LOW, l);
    chk({h, l}, {6'h00, v});
  endtask

  task automatic t_regs();
    logic [7:0] q;
    for (int i = 0; i < 10; i++) begin
      rdchk(8'(i * 4), 8'h00);
    end
    wr(OFS_CONTROL_0, 8'hFF);
    rdchk(OFS_CONTROL_0, 8'hF8);
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_CONTROL_1, 8'hA5);
    rdchk(OFS_CONTROL_1, 8'hA5);
    wr(OFS_CONTROL_1, 8'h00);
    // Byte lane 0 not selected: nothing stored
    wb(1'b1, OFS_CONTROL_1, 8'h3C, 4'hE, q);
    rdchk(OFS_CONTROL_1, 8'h00);
    wr(OFS_PERIOD_LOW, 8'hC3);
    wr(OFS_PERIOD_HIGH, 8'hFE);
    rdchk(OFS_PERIOD_HIGH, 8'h02);
    rdchk(OFS_PERIOD_LOW, 8'hC3);
    wr(OFS_CMP_A_LOW, 8'h77);
    rdchk(OFS_CMP_A_HIGH, 8'h00);
    rdchk(OFS_CMP_A_LOW, 8'h00);
  endtask

  task automatic t_count();
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_CONTROL_1, 8'hC0);
    setv(OFS_PERIOD_LOW, 10'h000);
    setv(OFS_CMP_A_LOW, 10'h000);
    wr(OFS_CONTROL_0, 8'h68);
    i_timer_pin_partner.pulse(5);
    cnt_chk(10'd5);
    wr(OFS_CONTROL_0, 8'h78);
    i_timer_pin_partner.pulse(5);
    cnt_chk(10'd10);
    wr(OFS_CONTROL_0, 8'hF8);
    i_timer_pin_partner.pulse(3);
    cnt_chk(10'd10);
    wr(OFS_CONTROL_0, 8'h78);
    i_timer_pin_partner.pulse(2);
    cnt_chk(10'd12);
    wr(OFS_CONTROL_0, 8'h70);
    i_timer_pin_partner.pulse(2);
    cnt_chk(10'd12);
    wr(OFS_COUNT_LOW, 8'h55);
    wr(OFS_COUNT_HIGH, 8'h01);
    cnt_chk(10'd12);
    wr(OFS_CONTROL_0, 8'h78);
    cnt_chk(10'd0);
    wr(OFS_CONTROL_0, 8'h00);
    setv(OFS_PERIOD_LOW, 10'd4);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_CONTROL_0, 8'h68);
    i_timer_pin_partner.pulse(6);
    cnt_chk(10'd2);
    chk({14'h0000, fa, fp}, 16'h0001);
  endtask

  task automatic t_compare();
    logic [3:0] kk;
    logic e;
    setv(OFS_CMP_A_LOW, 10'd3);
    setv(OFS_PERIOD_LOW, 10'd2);
    for (int k = 0; k < 16; k++) begin
      kk = 4'(k);
      wr(OFS_CONTROL_0, 8'h00);
      wr(OFS_CONTROL_1, {2'b00, kk[1:0], kk[2], kk[3], 2'b01});
      wr(OFS_FLAGS, 8'h03);
      wr(OFS_CONTROL_0, 8'h68);
      settle(2);
      chk({15'h0000, pin}, {15'h0000, kk[2] ^ kk[3]});
      i_timer_pin_partner.pulse(3);
      settle(4);
      e = (kk[1:0] == 2'h0) ? kk[2] : (kk[1:0] == 2'h1) ? 1'b0 :
          (kk[1:0] == 2'h2) ? 1'b1 : ~kk[2];
      chk({15'h0000, pin}, {15'h0000, e ^ kk[3]});
      chk({15'h0000, pinb}, {15'h0000, ~(e ^ kk[3])});
      chk({14'h0000, fa, fp}, 16'h0002);
    end
  endtask

  task automatic t_pwm();
    logic [1:0] fn;
    setv(OFS_CMP_A_LOW, 10'd5);
    setv(OFS_PERIOD_LOW, 10'd4);
    for (int k = 0; k < 3; k++) begin
      fn = 2'(k);
      wr(OFS_CONTROL_0, 8'h00);
      wr(OFS_CONTROL_1, {2'b10, fn, 4'b1001});
      wr(OFS_FLAGS, 8'h03);
      wr(OFS_CONTROL_0, 8'h68);
      i_timer_pin_partner.pulse(6);
      settle(2);
      chk({15'h0000, pin}, {15'h0000, fn != 2'h0});
      chk({15'h0000, fp}, 16'h0001);
    end
  endtask

  task automatic t_capture();
    logic [1:0] fn;
    setv(OFS_PERIOD_LOW, 10'd0);
    for (int k = 0; k < 4; k++) begin
      fn = 2'(k);
      wr(OFS_CONTROL_0, 8'h00);
      wr(OFS_CONTROL_1, {2'b01, fn, 4'b0000});
      wr(OFS_FLAGS, 8'h03);
      wr(OFS_CONTROL_0, 8'h38);
      i_timer_pin_partner.set_capture(1'b1);
      settle(6);
      chk({15'h0000, fa}, {15'h0000, fn == 2'h0 || fn == 2'h2});
      wr(OFS_FLAGS, 8'h03);
      i_timer_pin_partner.set_capture(1'b0);
      settle(6);
      chk({15'h0000, fa}, {15'h0000, fn == 2'h1 || fn == 2'h2});
    end
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_CONTROL_1, 8'h42);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_CONTROL_0, 8'h38);
    i_timer_pin_partner.set_capture(1'b1);
    settle(6);
    chk({15'h0000, fa}, 16'h0000);
    i_timer_pin_partner.pulse(1);
    settle(2);
    chk({15'h0000, fa}, 16'h0001);
  endtask

  // Single pulse: pin edge starts it, compare A match ends it
  task automatic t_pulse();
    wr(OFS_CONTROL_0, 8'h10);
    wr(OFS_CONTROL_1, 8'hB8);
    setv(OFS_CMP_A_LOW, 10'd5);
    wr(OFS_FLAGS, 8'h03);
    settle(2);
    chk({15'h0000, pin}, 16'h0000);
    i_timer_pin_partner.pulse(1);
    settle(0);
    chk({15'h0000, pin}, 16'h0001);
    settle(4);
    chk({14'h0000, fa, pin}, 16'h0002);
    rdchk(OFS_CONTROL_0, 8'h10);
  endtask

  // Mid-run reset must bring registers and outputs back to idle
  task automatic t_reset();
    wr(OFS_CONTROL_1, 8'h5A);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(OFS_CONTROL_1, 8'h00);
    chk({13'h0000, fa, fp, pinb}, 16'h0001);
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat_i = 32'h00000000;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_count();
    t_compare();
    t_pwm();
    t_capture();
    t_pulse();
    t_reset();
    wrap_up();
  end
endmodule

// ### verification/timer_pin_partner.sv
// Pin-side model driving the external clock and capture pins
`timescale 1ns/100ps
module timer_pin_partner (
  // Clock
  input wire logic clk,
  // Pins toward the timer
  output logic external_clock_pin,
  output logic capture_input_pin
);
  initial begin
    external_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
  end
  // Levels held 4 clocks so the two-flop sampler never misses one
  task automatic pulse(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk);
      external_clock_pin <= ~external_clock_pin;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic set_capture(input logic v);
    @(posedge clk);
    capture_input_pin <= v;
  endtask
endmodule

// ### verilog/periodic_timer.sv
// 10-bit periodic timer with Wishbone registers
// How it works
// - 10-bit up-counter on chosen clock or pin
// - Comparators A and P on all ten bits
// - Counter zeroed on timer-on rise and on clear match
// - Overflow or compare match raises request flag
// - Pause holds counter, resumes from held value
// - Clock select picks divided, sub or pin
// - Timer off stops counter, keeps residual value
// - Timer-on rise forces pin to initial level in compare mode
// - Mode field picks compare, capture, PWM, timer
// - Compare A match: none, low, high, toggle
// - Requested level equal initial shows no change
// - PWM pin: inactive, active, PWM, single pulse
// - Capture edges: rise, fall, both, disabled
// - Initial level bit: start or active level
// - Polarity bit inverts primary output pin
// - Inverted pin always opposite of primary
// - Capture source: capture pin or clock pin
// - Clear on A match, else P or overflow
// - Clear select ignored in PWM and capture
// - Count read-only, compares read/write byte pairs
// - Low bytes pass through shared byte buffer
// - No period flag when clearing on A
// - PWM period from P, duty from A
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
module periodic_timer
  import periodic_timer_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer pins
  input wire logic external_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_output_pin,
  output logic timer_output_inverted_pin,
  // Request flags
  output logic compare_a_match_flag,
  output logic period_match_flag
);
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [9:0] cnt;
    logic [9:0] cmp_a;
    logic [9:0] period;
    logic [7:0] low_buf;
    logic flag_a;
    logic flag_p;
    logic on_prev;
    logic out_state;
    logic pin;
    logic pin_n;
    logic ack;
    logic [7:0] rdata;
  } state_s;
  state_s st;
  state_s next_st;
  logic [1:0] rst_sync;
  logic rst_n;
  logic t_sys4;
  logic t_h16;
  logic t_h64;
  logic t_sub;
  logic ext_rise;
  logic ext_fall;
  logic cap_rise;
  logic cap_fall;

  // Reset released through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  tick_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .tick_sys4(t_sys4),
    .tick_h16(t_h16),
    .tick_h64(t_h64),
    .tick_sub(t_sub)
  );

  pin_edge_detect u_ext (
    .clk(clk),
    .rst_n(rst_n),
    .pin(external_clock_pin),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  pin_edge_detect u_cap (
    .clk(clk),
    .rst_n(rst_n),
    .pin(capture_input_pin),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  function automatic logic [7:0] high_byte(input logic [9:0] v);
    return {6'h00, v[9:8]};
  endfunction

  mode_e mode;
  logic [1:0] pin_fn;
  logic init_lvl;
  logic timer_on;
  logic on_rise;
  logic tick;
  logic run;
  logic [9:0] inc;
  logic match_a;
  logic match_p;
  logic clear_on_a;
  logic do_clear;
  logic src_rise;
  logic src_fall;
  logic cap_evt;
  logic single;
  logic raw;
  logic req;
  logic wr;

  always_comb begin
    next_st = st;
    mode = mode_e'(st.ctrl1[MODE_LSB +: 2]);
    pin_fn = st.ctrl1[PIN_FN_LSB +: 2];
    init_lvl = st.ctrl1[INIT_LEVEL_BIT];
    timer_on = st.ctrl0[TIMER_ON_BIT];
    on_rise = timer_on & ~st.on_prev;
    next_st.on_prev = timer_on;
    case (st.ctrl0[CLK_SEL_LSB +: 3])
      CKS_SYS4: tick = t_sys4;
      CKS_SYS: tick = 1'b1;
      CKS_H16: tick = t_h16;
      CKS_H64: tick = t_h64;
      CKS_SUB0: tick = t_sub;
      CKS_SUB1: tick = t_sub;
      CKS_EXT_RISE: tick = ext_rise;
      default: tick = ext_fall;
    endcase
    // Paused or off: no advance, value retained
    run = tick & timer_on & ~st.ctrl0[PAUSE_BIT] & ~on_rise;
    inc = st.cnt + 10'h001;
    // A value of zero never matches A, so the counter overflows
    match_a = (inc == st.cmp_a) && (st.cmp_a != VALUE_RESET);
    // Period zero matches at the wrap to zero, i.e. overflow
    match_p = (inc == st.period);
    clear_on_a = st.ctrl1[CLEAR_SEL_BIT] &&
                 (mode == MODE_COMPARE || mode == MODE_TIMER);
    do_clear = clear_on_a ? match_a : match_p;
    single = (mode == MODE_PWM) && (pin_fn == PF_3);
    src_rise = st.ctrl1[CAP_SRC_BIT] ? ext_rise : cap_rise;
    src_fall = st.ctrl1[CAP_SRC_BIT] ? ext_fall : cap_fall;
    case (pin_fn)
      PF_0: cap_evt = src_rise;
      PF_1: cap_evt = src_fall;
      PF_2: cap_evt = src_rise | src_fall;
      default: cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt & timer_on & (mode == MODE_CAPTURE);

    // Counter and output state
    if (on_rise) begin
      next_st.cnt = VALUE_RESET;
      next_st.out_state = init_lvl;
    end else if (run) begin
      next_st.cnt = do_clear ? VALUE_RESET : inc;
      if (match_a && mode == MODE_COMPARE) begin
        case (pin_fn)
          PF_1: next_st.out_state = 1'b0;
          PF_2: next_st.out_state = 1'b1;
          PF_3: next_st.out_state = ~st.out_state;
          default: next_st.out_state = st.out_state;
        endcase
      end
    end
    if (cap_evt) begin
      next_st.cmp_a = st.cnt;
    end

    // Output pin; held in timer/counter and capture modes
    case (mode)
      MODE_COMPARE: raw = st.out_state;
      MODE_PWM: begin
        case (pin_fn)
          PF_0: raw = ~init_lvl;
          PF_1: raw = init_lvl;
          PF_2: raw = (st.cnt < st.cmp_a) ? init_lvl : ~init_lvl;
          default: raw = timer_on ? init_lvl : ~init_lvl;
        endcase
      end
      default: raw = st.pin ^ st.ctrl1[POLARITY_BIT];
    endcase
    next_st.pin = raw ^ st.ctrl1[POLARITY_BIT];
    next_st.pin_n = ~next_st.pin;

    // Register bus, answered one edge after the request
    req = wb_cyc_i & wb_stb_i & ~st.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    next_st.ack = req;
    if (req) begin
      next_st.rdata = 8'h00;
    end
    if (req && wb_adr_i == OFS_CONTROL_0) begin
      next_st.rdata = st.ctrl0;
      if (wr) begin
        next_st.ctrl0 = wb_dat_i[7:0] & CONTROL_0_MASK;
      end
    end else if (req && wb_adr_i == OFS_CONTROL_1) begin
      next_st.rdata = st.ctrl1;
      if (wr) begin
        next_st.ctrl1 = wb_dat_i[7:0];
      end
    end else if (req && wb_adr_i == OFS_COUNT_LOW) begin
      next_st.rdata = st.low_buf;
    end else if (req && wb_adr_i == OFS_COUNT_HIGH) begin
      next_st.rdata = high_byte(st.cnt);
      if (!wb_we_i) begin
        next_st.low_buf = st.cnt[7:0];
      end
    end else if (req && (wb_adr_i == OFS_CMP_A_LOW || wb_adr_i == OFS_PERIOD_LOW)) begin
      next_st.rdata = st.low_buf;
      if (wr) begin
        next_st.low_buf = wb_dat_i[7:0];
      end
    end else if (req && wb_adr_i == OFS_CMP_A_HIGH) begin
      next_st.rdata = high_byte(st.cmp_a);
      if (wr) begin
        next_st.cmp_a = {wb_dat_i[1:0], st.low_buf};
      end else if (!wb_we_i) begin
        next_st.low_buf = st.cmp_a[7:0];
      end
    end else if (req && wb_adr_i == OFS_PERIOD_HIGH) begin
      next_st.rdata = high_byte(st.period);
      if (wr) begin
        next_st.period = {wb_dat_i[1:0], st.low_buf};
      end else if (!wb_we_i) begin
        next_st.low_buf = st.period[7:0];
      end
    end else if (req && wb_adr_i == OFS_FLAGS) begin
      next_st.rdata = {6'h00, st.flag_p, st.flag_a};
      if (wr && wb_dat_i[FLAG_A_BIT]) begin
        next_st.flag_a = 1'b0;
      end
      if (wr && wb_dat_i[FLAG_P_BIT]) begin
        next_st.flag_p = 1'b0;
      end
    end

    // Hardware events after the bus so a set beats a clear
    if ((run && match_a && mode != MODE_CAPTURE) || cap_evt) begin
      next_st.flag_a = 1'b1;
    end
    if (run && match_p && !clear_on_a) begin
      next_st.flag_p = 1'b1;
    end
    // Single pulse: pin edge starts, A match ends the pulse
    if (single && ext_rise && !timer_on) begin
      next_st.ctrl0[TIMER_ON_BIT] = 1'b1;
    end else if (single && run && match_a) begin
      next_st.ctrl0[TIMER_ON_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl0 <= CONTROL_RESET;
      st.ctrl1 <= CONTROL_RESET;
      st.pin_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = {24'h000000, st.rdata};
  assign wb_ack_o = st.ack;
  assign timer_output_pin = st.pin;
  assign timer_output_inverted_pin = st.pin_n;
  assign compare_a_match_flag = st.flag_a;
  assign period_match_flag = st.flag_p;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence start_s;
    on_rise && mode == MODE_COMPARE;
  endsequence
  sequence init_pin_s;
    ##1 st.out_state == $past(init_lvl) ##1 st.pin == $past(st.out_state ^ st.ctrl1[POLARITY_BIT]);
  endsequence

  counter_zero_a: assert property (on_rise |=> st.cnt == VALUE_RESET)
    else $error("counter not zeroed by timer on");
  pause_hold_a: assert property (st.ctrl0[PAUSE_BIT] && !on_rise |=> $stable(st.cnt))
    else $error("counter moved while paused");
  off_hold_a: assert property (!timer_on |=> st.cnt == $past(st.cnt))
    else $error("counter moved while off");
  pin_init_a: assert property (start_s |-> init_pin_s)
    else $error("pin not set to initial level");
  pin_inverse_a: assert property (timer_output_inverted_pin == !timer_output_pin)
    else $error("inverted pin not opposite");
  flag_a_set_a: assert property (run && match_a && mode == MODE_COMPARE |=> st.flag_a)
    else $error("compare A flag not raised");
  no_p_flag_a: assert property (clear_on_a && !st.flag_p && !$past(clear_on_a) == 0 |=> !st.flag_p)
    else $error("period flag raised while clearing on A");
  count_read_a: assert property (req && !wb_we_i && wb_adr_i == OFS_COUNT_HIGH |=>
    wb_ack_o && wb_dat_o[7:0] == {6'h00, $past(st.cnt[9:8])} ##1 !wb_ack_o)
    else $error("count high read wrong");
  full_duty_a: assert property (mode == MODE_PWM && pin_fn == PF_2 && st.cmp_a >= st.period &&
    st.period != VALUE_RESET && $stable(st.ctrl1) |=> st.pin == (init_lvl ^ st.ctrl1[POLARITY_BIT]))
    else $error("duty not full at or above period");
endmodule

// ### verilog/pin_edge_detect.sv
// Two-flop pin synchroniser with edge pulses
`timescale 1ns/100ps
module pin_edge_detect
  import periodic_timer_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and edges
  input wire logic pin,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } state_s;
  state_s st;
  state_s next_st;

  always_comb begin
    next_st = st;
    next_st.meta = pin;
    next_st.sync = st.meta;
    next_st.last = st.sync;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Edges only from the second flop, meta is never decoded
  assign rise = st.sync & ~st.last;
  assign fall = ~st.sync & st.last;
endmodule

// ### verilog/tick_divider.sv
// Counter clock enables derived from the system clock
`timescale 1ns/100ps
module tick_divider
  import periodic_timer_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // One-cycle enables
  output logic tick_sys4,
  output logic tick_h16,
  output logic tick_h64,
  output logic tick_sub
);
  typedef struct packed {
    logic [5:0] div;
    logic [7:0] sub;
    logic t4;
    logic t16;
    logic t64;
    logic tsub;
  } state_s;
  state_s st;
  state_s next_st;

  function automatic logic at_mask(input logic [5:0] v, input logic [5:0] m);
    return (v & m) == m;
  endfunction

  // High clock taken as the system clock; sub clock is a slow divide
  always_comb begin
    next_st = st;
    next_st.div = st.div + 6'h01;
    next_st.t4 = at_mask(st.div, SYS4_MASK);
    next_st.t16 = at_mask(st.div, H16_MASK);
    next_st.t64 = at_mask(st.div, H64_MASK);
    next_st.tsub = (st.sub == SUB_DIV_LAST);
    next_st.sub = next_st.tsub ? 8'h00 : st.sub + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_sys4 = st.t4;
  assign tick_h16 = st.t16;
  assign tick_h64 = st.t64;
  assign tick_sub = st.tsub;
endmodule
